// >>> design/smcu_buf2.sv
// two-entry instruction byte buffer with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "smcu_regs.svh"
module smcu_buf2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] slotMem [`SMCU_BUF_DEPTH];
  logic             wrPtr_reg;
  logic             rdPtr_reg;
  logic [1:0]       count_reg;
  logic [1:0]       count_next;
  logic             inReady_reg;
  logic             pushFire;
  logic             popFire;

  // handshakes; ready is kept equal to not-full
  assign pushFire   = inValid && inReady_reg;
  assign popFire    = outValid && outReady;
  assign count_next = count_reg + {1'b0, pushFire} - {1'b0, popFire};
  assign inReady    = inReady_reg;
  assign outValid   = (count_reg != 2'h0);
  assign outData    = slotMem[rdPtr_reg];

  // storage has no reset; only pointers matter
  always_ff @(posedge clk_sys) begin
    if (pushFire) begin
      slotMem[wrPtr_reg] <= inData;
    end
  end

  // pointers and registered ready
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr_reg   <= 1'b0;
      rdPtr_reg   <= 1'b0;
      count_reg   <= 2'h0;
      inReady_reg <= 1'b1;
    end else begin
      wrPtr_reg   <= wrPtr_reg ^ pushFire;
      rdPtr_reg   <= rdPtr_reg ^ popFire;
      count_reg   <= count_next;
      inReady_reg <= (count_next != 2'h2);
    end
  end

  a_buf_nooverflow : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (count_reg == 2'h2) |-> !inReady)
    else $error("buffer accepts while full");
endmodule

// >>> design/smcu_core.sv
// decode core: transfer, table load, status and add instructions, port-2 specials
// assumes opcode bytes arrive in order on a valid/ready stream, one clock,
// host strobes and port-2 pins come from outside the clock domain
//
// Overview of operation
// - after reset port-2 bits 6 and 7 are plain port bits
// - handshake-enable turns port-2 bit 6 into transfer request output
// - with handshake enabled, writing one to bit 6 raises request
// - request clears on acknowledged read, acknowledged write, or handshake-enable again
// - handshake-enable makes bit 7 the acknowledge input, used as select
// - during transfers the normal chip select is ignored
// - after reset port-2 bits 4 and 5 are plain inputs
// - flag-enable puts output-full on bit 4, inverted input-full on bit 5
// - flag shows on pin only while one is written to that bit
// - bit 4 shows output data waiting, bit 5 shows input can accept
// - load immediate: two bytes, two cycles, immediate into accumulator
// - register moves are one cycle, low three opcode bits pick register
// - indirect moves use register 0 or 1 by opcode bit 0
// - page table load reads current page at accumulator, two cycles
// - page three table load reads page 3 at accumulator, two cycles
// - nibble exchange swaps low four bits with indirect memory byte
// - status word write loads all bits, bit 7 carry, 6 aux
// - status word read copies whole word into accumulator
// - host status write updates only bits 4 to 7
// - carry clear forces zero, carry complement inverts, one cycle
// - user flag zero clear and complement, one cycle each
// - add stores sum, carries set on overflow else cleared
`timescale 1ns/1ps
`include "smcu_regs.svh"
module smcu_core (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       opValid,
  input  wire logic [7:0]                 opByte,
  output logic                            opReady,
  input  wire logic [1:0]                 curPage,
  output smcu_pkg::smcu_tbl_req_type      tblReq,
  input  wire logic                       tblDataValid,
  input  wire logic [7:0]                 tblData,
  input  wire logic [7:0]                 p2In,
  output smcu_pkg::smcu_p2_drive_type     p2Drive,
  input  wire logic                       hostCs_n,
  input  wire logic                       hostRd_n,
  input  wire logic                       hostWr_n,
  output logic                            hostSel,
  input  wire logic                       outputBufferFullFlag,
  input  wire logic                       inputBufferFullFlag,
  output logic [3:0]                      hostStatusUpper,
  output logic [7:0]                      accumOut,
  output smcu_pkg::smcu_psw_type          statusWordOut
);
  // state
  smcu_pkg::smcu_state_type     state_reg;
  smcu_pkg::smcu_state_type     state_next;
  logic [7:0]                   accum_reg;
  logic [7:0]                   accum_next;
  smcu_pkg::smcu_psw_type       psw_reg;
  smcu_pkg::smcu_psw_type       psw_next;
  logic [3:0]                   hostStatus_reg;
  logic [7:0]                   p2Latch_reg;
  logic                         p2Written_reg;
  logic                         xferEn_reg;
  logic                         flagsEn_reg;
  logic                         transferRequestOut_reg;
  logic                         transferRequestOut_next;
  logic                         rdPrev_reg;
  logic                         wrPrev_reg;
  smcu_pkg::smcu_tbl_req_type   tblReq_reg;
  smcu_pkg::smcu_p2_drive_type  p2Drive_reg;
  smcu_pkg::smcu_p2_drive_type  p2Drive_next;
  logic                         hostSel_reg;
  logic [7:0]                   dataMem [`SMCU_RAM_WORDS];
  // pin synchronisers: p2 bits, cs, rd, wr
  logic [10:0]                  syncA_reg;
  logic [10:0]                  syncB_reg;
  logic [10:0]                  syncC_reg;
  logic [10:0]                  pinFilt_reg;

  // buffer side
  logic       bufValid;
  logic [7:0] bufData;
  logic       coreReady;

  smcu_buf2 #(
    .WIDTH (8)
  ) u_buf (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inValid  (opValid),
    .inData   (opByte),
    .inReady  (opReady),
    .outValid (bufValid),
    .outData  (bufData),
    .outReady (coreReady)
  );

  // accept opcodes in fetch, immediates in imm; stall during table wait
  assign coreReady = (state_reg == smcu_pkg::ST_FETCH) || (state_reg == smcu_pkg::ST_IMM);
  logic opFire;
  logic immFire;
  logic tblDone;
  assign opFire  = bufValid && (state_reg == smcu_pkg::ST_FETCH);
  assign immFire = bufValid && (state_reg == smcu_pkg::ST_IMM);
  assign tblDone = tblDataValid && (state_reg == smcu_pkg::ST_TABLE);

  // opcode decode
  logic isMovImm, isMovAR, isMovRA, isMovAInd, isMovIndA, isPage, isPage3, isXchd;
  logic isRdPsw, isWrPsw, isWrHost, isClrC, isCplC, isClrF0, isCplF0;
  logic isAddImm, isAddR, isAddInd, isCarryIn, isEnXfer, isEnFlags, isOutP2, isInP2;
  assign isMovImm  = (bufData == `SMCU_OP_MOV_A_IMM);
  assign isMovAR   = (bufData[7:3] == `SMCU_OPH_MOV_A_R);
  assign isMovRA   = (bufData[7:3] == `SMCU_OPH_MOV_R_A);
  assign isMovAInd = (bufData[7:1] == `SMCU_OPI_MOV_A_IND);
  assign isMovIndA = (bufData[7:1] == `SMCU_OPI_MOV_IND_A);
  assign isPage    = (bufData == `SMCU_OP_PAGE_LOAD);
  assign isPage3   = (bufData == `SMCU_OP_PAGE3_LOAD);
  assign isXchd    = (bufData[7:1] == `SMCU_OPI_NIBBLE_EXCHANGE);
  assign isRdPsw   = (bufData == `SMCU_OP_RD_STATUS);
  assign isWrPsw   = (bufData == `SMCU_OP_WR_STATUS);
  assign isWrHost  = (bufData == `SMCU_OP_WR_HOST);
  assign isClrC    = (bufData == `SMCU_OP_CLR_CARRY);
  assign isCplC    = (bufData == `SMCU_OP_CPL_CARRY);
  assign isClrF0   = (bufData == `SMCU_OP_CLR_UFLAG);
  assign isCplF0   = (bufData == `SMCU_OP_CPL_UFLAG);
  assign isAddImm  = (bufData == `SMCU_OP_ADD_IMM) || (bufData == `SMCU_OP_ADDC_IMM);
  assign isAddR    = (bufData[7:3] == `SMCU_OPH_ADD_R) || (bufData[7:3] == `SMCU_OPH_ADDC_R);
  assign isAddInd  = (bufData[7:1] == `SMCU_OPI_ADD_IND) || (bufData[7:1] == `SMCU_OPI_ADDC_IND);
  assign isCarryIn = bufData[4];   // addc forms differ from add in bit 4
  assign isEnXfer  = (bufData == `SMCU_OP_EN_XFER);
  assign isEnFlags = (bufData == `SMCU_OP_EN_FLAGS);
  assign isOutP2   = (bufData == `SMCU_OP_OUT_P2);
  assign isInP2    = (bufData == `SMCU_OP_IN_P2);

  // immediate-form add waits for its second byte; remember the carry-in choice
  logic immIsAdd_reg;
  logic immCarry_reg;

  // operand fetch from working registers and indirect memory
  logic [5:0] regAddr;
  logic [7:0] regVal;
  logic [5:0] indAddr;
  logic [7:0] indVal;
  assign regAddr = {3'h0, bufData[2:0]};
  assign regVal  = dataMem[regAddr];
  assign indAddr = dataMem[{5'h00, bufData[0]}][5:0];
  assign indVal  = dataMem[indAddr];

  // adder shared by all add forms, carries from bit 7 and bit 3
  logic [7:0] addOperand;
  logic       addCin;
  logic [8:0] addSum;
  logic [4:0] addLow;
  assign addOperand = immFire ? bufData : (isAddInd ? indVal : regVal);
  assign addCin     = (immFire ? immCarry_reg : isCarryIn) & psw_reg.carry;
  assign addSum     = {1'b0, accum_reg} + {1'b0, addOperand} + {8'h00, addCin};
  assign addLow     = {1'b0, accum_reg[3:0]} + {1'b0, addOperand[3:0]} + {4'h0, addCin};

  // memory writes: register move, indirect move, nibble exchange
  logic       memWr;
  logic [5:0] memAddr;
  logic [7:0] memData;
  assign memWr   = opFire && (isMovRA || isMovIndA || isXchd);
  assign memAddr = isMovRA ? regAddr : indAddr;
  assign memData = isXchd ? {indVal[7:4], accum_reg[3:0]} : accum_reg;

  // working memory has no reset, as on a real part
  always_ff @(posedge clk_sys) begin
    if (memWr) begin
      dataMem[memAddr] <= memData;
    end
  end

  // accumulator and status word next values
  always_comb begin
    accum_next = accum_reg;
    psw_next   = psw_reg;
    if (tblDone) begin
      accum_next = tblData;
    end else if (immFire && !immIsAdd_reg) begin
      accum_next = bufData;
    end else if ((immFire && immIsAdd_reg) || (opFire && (isAddR || isAddInd))) begin
      accum_next        = addSum[7:0];
      psw_next.carry    = addSum[8];
      psw_next.auxCarry = addLow[4];
    end else if (opFire) begin
      if (isMovAR)   accum_next = regVal;
      if (isMovAInd) accum_next = indVal;
      if (isXchd)    accum_next = {accum_reg[7:4], indVal[3:0]};
      if (isRdPsw)   accum_next = psw_reg;
      if (isInP2)    accum_next = pinFilt_reg[7:0];
      if (isWrPsw)   psw_next = accum_reg;
      if (isClrC)    psw_next.carry = 1'b0;
      if (isCplC)    psw_next.carry = !psw_reg.carry;
      if (isClrF0)   psw_next.userFlagZero = 1'b0;
      if (isCplF0)   psw_next.userFlagZero = !psw_reg.userFlagZero;
    end
  end

  // sequencer: immediate byte and table reads take a second cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      smcu_pkg::ST_FETCH: begin
        if (opFire && (isMovImm || isAddImm)) state_next = smcu_pkg::ST_IMM;
        if (opFire && (isPage || isPage3))    state_next = smcu_pkg::ST_TABLE;
      end
      smcu_pkg::ST_IMM: begin
        if (immFire) state_next = smcu_pkg::ST_FETCH;
      end
      smcu_pkg::ST_TABLE: begin
        if (tblDone) state_next = smcu_pkg::ST_FETCH;
      end
      default: state_next = smcu_pkg::ST_FETCH;
    endcase
  end

  // filtered host strobes and acknowledge pin
  logic ackLevel;
  logic rdFall;
  logic wrFall;
  logic ackRead;
  logic ackWrite;
  assign ackLevel = pinFilt_reg[`SMCU_P2_ACK_BIT];
  assign rdFall   = rdPrev_reg && !pinFilt_reg[9];
  assign wrFall   = wrPrev_reg && !pinFilt_reg[10];
  assign ackRead  = xferEn_reg && ackLevel && rdFall;
  assign ackWrite = xferEn_reg && ackLevel && wrFall;

  // request: a write of one sets it and wins over a clear in the same cycle
  logic reqSet;
  logic reqClr;
  assign reqSet = opFire && isOutP2 && xferEn_reg && accum_reg[`SMCU_P2_REQ_BIT];
  assign reqClr = ackRead || ackWrite || (opFire && isEnXfer);
  assign transferRequestOut_next = reqSet || (transferRequestOut_reg && !reqClr);

  // pin drive: latch value unless a special function owns the bit
  always_comb begin
    p2Drive_next.level = p2Latch_reg;
    p2Drive_next.oeN   = p2Written_reg ? 8'h00 : `SMCU_P2_RESET;
    if (xferEn_reg) begin
      p2Drive_next.level[`SMCU_P2_REQ_BIT] = transferRequestOut_reg;
      p2Drive_next.oeN[`SMCU_P2_REQ_BIT]   = 1'b0;
      p2Drive_next.oeN[`SMCU_P2_ACK_BIT]   = 1'b1;
    end
    if (flagsEn_reg) begin
      // flag is gated by the latched bit; a zero hides it
      p2Drive_next.level[`SMCU_P2_OBF_BIT] = p2Latch_reg[`SMCU_P2_OBF_BIT]
                                             && outputBufferFullFlag;
      p2Drive_next.level[`SMCU_P2_IBF_BIT] = p2Latch_reg[`SMCU_P2_IBF_BIT]
                                             && !inputBufferFullFlag;
      p2Drive_next.oeN[`SMCU_P2_OBF_BIT]   = 1'b0;
      p2Drive_next.oeN[`SMCU_P2_IBF_BIT]   = 1'b0;
    end
  end

  // three-stage pin sampling; a change counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syncA_reg   <= 11'h7ff;
      syncB_reg   <= 11'h7ff;
      syncC_reg   <= 11'h7ff;
      pinFilt_reg <= 11'h7ff;
    end else begin
      syncA_reg   <= {hostWr_n, hostRd_n, hostCs_n, p2In};
      syncB_reg   <= syncA_reg;
      syncC_reg   <= syncB_reg;
      pinFilt_reg <= (syncB_reg & syncC_reg) | (pinFilt_reg & (syncB_reg | syncC_reg));
    end
  end

  // core state registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg    <= smcu_pkg::ST_FETCH;
      accum_reg    <= 8'h00;
      psw_reg      <= `SMCU_PSW_RESET;
      immIsAdd_reg <= 1'b0;
      immCarry_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      accum_reg    <= accum_next;
      psw_reg      <= psw_next;
      immIsAdd_reg <= (opFire && isAddImm) ? 1'b1 : (immFire ? 1'b0 : immIsAdd_reg);
      immCarry_reg <= (opFire && isAddImm) ? isCarryIn : immCarry_reg;
    end
  end

  // port, special-function and host-side registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      p2Latch_reg            <= `SMCU_P2_RESET;
      p2Written_reg          <= 1'b0;
      xferEn_reg             <= 1'b0;
      flagsEn_reg            <= 1'b0;
      transferRequestOut_reg <= 1'b0;
      hostStatus_reg         <= 4'h0;
      rdPrev_reg             <= 1'b1;
      wrPrev_reg             <= 1'b1;
    end else begin
      if (opFire && isOutP2) p2Latch_reg <= accum_reg;
      p2Written_reg          <= p2Written_reg || (opFire && isOutP2);
      xferEn_reg             <= xferEn_reg || (opFire && isEnXfer);
      flagsEn_reg            <= flagsEn_reg || (opFire && isEnFlags);
      transferRequestOut_reg <= transferRequestOut_next;
      if (opFire && isWrHost) hostStatus_reg <= accum_reg[7:4];
      rdPrev_reg             <= pinFilt_reg[9];
      wrPrev_reg             <= pinFilt_reg[10];
    end
  end

  // registered outputs; table request issued with the opcode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tblReq_reg  <= '0;
      p2Drive_reg <= {`SMCU_P2_RESET, `SMCU_P2_RESET};
      hostSel_reg <= 1'b0;
    end else begin
      if (opFire && isPage)  tblReq_reg <= {1'b1, curPage, accum_reg};
      if (opFire && isPage3) tblReq_reg <= {1'b1, `SMCU_PAGE_THREE, accum_reg};
      if (tblDone)           tblReq_reg.valid <= 1'b0;
      p2Drive_reg <= p2Drive_next;
      hostSel_reg <= xferEn_reg ? ackLevel : !pinFilt_reg[8];
    end
  end

  assign tblReq          = tblReq_reg;
  assign p2Drive         = p2Drive_reg;
  assign hostSel         = hostSel_reg;
  assign hostStatusUpper = hostStatus_reg;
  assign accumOut        = accum_reg;
  assign statusWordOut   = psw_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_req_plain_port : assert property (!xferEn_reg |=> p2Drive.level[6] == $past(p2Latch_reg[6]))
    else $error("bit 6 not plain before enable");
  a_req_enable_now : assert property (opFire && isEnXfer |=> xferEn_reg && !transferRequestOut_reg)
    else $error("enable did not take effect");
  a_req_raise_pin : assert property (reqSet |=> transferRequestOut_reg ##1 p2Drive.level[6])
    else $error("request not raised on pin");
  a_req_clear_ack : assert property ((ackRead || ackWrite) && !reqSet |=> !transferRequestOut_reg)
    else $error("request not cleared by acknowledge");
  a_sel_from_ack : assert property (xferEn_reg |=> hostSel == $past(ackLevel))
    else $error("select not taken from acknowledge");
  a_flag_hidden_zero : assert property (flagsEn_reg && !p2Latch_reg[4] |=> !p2Drive.level[4])
    else $error("flag shown while zero written");
  a_flag_ibf_route : assert property (flagsEn_reg && p2Latch_reg[5] |=> p2Drive.level[5] == !$past(inputBufferFullFlag))
    else $error("input flag not routed");
  a_flag_input_mode : assert property (!flagsEn_reg && !p2Written_reg |=> p2Drive.oeN[5:4] == 2'b11)
    else $error("flag pins driven before enable");
  a_imm_two_cycle : assert property (opFire && isMovImm ##1 immFire |=> accumOut == $past(bufData))
    else $error("immediate not loaded");
  a_tbl_page3_addr : assert property (opFire && isPage3 |=> tblReq.valid && tblReq.addr[9:8] == 2'h3)
    else $error("page three address wrong");
  a_host_upper_only : assert property (opFire && isWrHost |=> hostStatusUpper == $past(accum_reg[7:4]))
    else $error("host status not written");
  a_add_carry_out : assert property (opFire && isAddR |=> statusWordOut.carry == $past(addSum[8]))
    else $error("add carry wrong");

  c_dma_request : cover property (reqSet ##[1:50] ackRead);
  c_table_load : cover property (opFire && isPage ##[1:20] tblDone);
  c_flag_shown : cover property (flagsEn_reg && p2Drive.level[4]);
endmodule

// >>> design/smcu_pkg.sv
// types shared by the decode core, its bench and the far-side model
// assumes smcu_regs.svh is on the include path
package smcu_pkg;

  // sequencing states of the decode core
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_IMM   = 2'b01,
    ST_TABLE = 2'b10
  } smcu_state_type;

  // status word: carry, aux carry, user flag, bank, one (reset to zero, loaded by status write), stack
  typedef struct packed {
    logic       carry;
    logic       auxCarry;
    logic       userFlagZero;
    logic       bank;
    logic       one;
    logic [2:0] stack;
  } smcu_psw_type;

  // program memory table read request
  typedef struct packed {
    logic       valid;
    logic [9:0] addr;
  } smcu_tbl_req_type;

  // port-2 pin drive, enable low while driving
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oeN;
  } smcu_p2_drive_type;

endpackage

// >>> design/smcu_regs.svh
// constants for the slave controller decode block: opcodes, bit positions, reset values
// assumes inclusion by smcu_core.sv and smcu_buf2.sv only
`ifndef SMCU_REGS_SVH
`define SMCU_REGS_SVH

// one-byte opcodes matched in full
`define SMCU_OP_MOV_A_IMM   8'h23
`define SMCU_OP_PAGE_LOAD   8'ha3
`define SMCU_OP_PAGE3_LOAD  8'he3
`define SMCU_OP_RD_STATUS   8'hc7
`define SMCU_OP_WR_STATUS   8'hd7
`define SMCU_OP_WR_HOST     8'h90
`define SMCU_OP_CLR_CARRY   8'h97
`define SMCU_OP_CPL_CARRY   8'ha7
`define SMCU_OP_CLR_UFLAG   8'h85
`define SMCU_OP_CPL_UFLAG   8'h95
`define SMCU_OP_ADD_IMM     8'h03
`define SMCU_OP_ADDC_IMM    8'h13
`define SMCU_OP_EN_XFER     8'he5
`define SMCU_OP_EN_FLAGS    8'hf5
`define SMCU_OP_OUT_P2      8'h3a
`define SMCU_OP_IN_P2       8'h0a
// register forms: top five bits, low three select the register
`define SMCU_OPH_MOV_A_R    5'h1f
`define SMCU_OPH_MOV_R_A    5'h15
`define SMCU_OPH_ADD_R      5'h0d
`define SMCU_OPH_ADDC_R     5'h0f
// indirect forms: top seven bits, bit 0 picks register 0 or 1
`define SMCU_OPI_MOV_A_IND  7'h78
`define SMCU_OPI_MOV_IND_A  7'h50
`define SMCU_OPI_NIBBLE_EXCHANGE       7'h18
`define SMCU_OPI_ADD_IND    7'h30
`define SMCU_OPI_ADDC_IND   7'h38

// port-2 bit positions
`define SMCU_P2_OBF_BIT     4
`define SMCU_P2_IBF_BIT     5
`define SMCU_P2_REQ_BIT     6
`define SMCU_P2_ACK_BIT     7

`define SMCU_PAGE_THREE     2'h3
`define SMCU_PSW_RESET      8'h00
`define SMCU_P2_RESET       8'hff
`define SMCU_RAM_WORDS      64
`define SMCU_BUF_DEPTH      2

`endif

// >>> testbench/smcu_core_bench.sv
// bench for smcu_core: hand-written scenarios against a far-side model
// assumes 10 MHz clock and synchronous active-low reset
`timescale 1ns/1ps
module smcu_core_bench;
  logic                        clk_sys = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        opValid = 1'b0;
  logic [7:0]                  opByte = 8'h00;
  logic                        opReady, tblDataValid, hostSel, ackPin, rdPin_n, wrPin_n;
  logic [1:0]                  curPage = 2'h1;
  logic [7:0]                  tblData, accumOut, p2In;
  logic                        hostCs_n = 1'b1;
  logic                        obfFlag = 1'b1;
  logic                        ibfFlag = 1'b0;
  logic                        dmaGo = 1'b0;
  logic                        dmaWrite = 1'b0;
  logic [3:0]                  hostStatusUpper;
  smcu_pkg::smcu_tbl_req_type  tblReq;
  smcu_pkg::smcu_p2_drive_type p2Drive;
  smcu_pkg::smcu_psw_type      statusWordOut;
  int                          fails = 0;
  int                          comparisons = 0;

  always #50 clk_sys = ~clk_sys;
  // released pins read high through the pull-up
  assign p2In = {ackPin, p2Drive.level[6:0] | p2Drive.oeN[6:0]};

  smcu_core dut_u (.clk_sys, .rst_n, .opValid, .opByte, .opReady, .curPage, .tblReq,
    .tblDataValid, .tblData, .p2In, .p2Drive, .hostCs_n, .hostRd_n(rdPin_n),
    .hostWr_n(wrPin_n), .hostSel, .outputBufferFullFlag(obfFlag),
    .inputBufferFullFlag(ibfFlag), .hostStatusUpper, .accumOut, .statusWordOut);
  smcu_far_side far_u (.clk_sys, .tblReq, .reqPin(p2Drive.level[6] & ~p2Drive.oeN[6]),
    .dmaGo, .dmaWrite, .tblDataValid, .tblData, .ackPin, .rdPin_n, .wrPin_n);

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bytes held until taken; results read well after the last one
  task automatic seq(input logic [7:0] b[$]);
    foreach (b[i]) begin
      opValid = 1'b1;
      opByte = b[i];
      while (opReady !== 1'b1) idle(1);
      idle(1);
    end
    opValid = 1'b0;
    idle(12);
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // register, indirect and nibble moves
  task automatic t_moves;
    seq('{8'h23, 8'h5a, 8'hab, 8'h23, 8'h00, 8'hfb});
    chk(accumOut, 8'h5a);
    seq('{8'h23, 8'h10, 8'ha9, 8'h23, 8'hc3, 8'ha1, 8'h23, 8'h0f, 8'h31, 8'hf1});
    chk(accumOut, 8'hcf);
  endtask
  // status word, host status and flag bits
  task automatic t_status;
    seq('{8'h23, 8'hc0, 8'hd7});
    chk(statusWordOut, 8'hc0);
    seq('{8'h97, 8'ha7, 8'h95, 8'hc7});
    chk(accumOut, 8'he0);
    seq('{8'h85, 8'h23, 8'ha5, 8'h90});
    chk({statusWordOut, 4'h0, hostStatusUpper}, 16'hc00a);
  endtask
  // immediate and register adds; the last one needs the carry-in
  task automatic t_add;
    seq('{8'h97, 8'h23, 8'hf0, 8'h03, 8'h20});
    chk({accumOut, 7'h00, statusWordOut.carry}, 16'h1001);
    seq('{8'h03, 8'h01});
    chk({accumOut, 7'h00, statusWordOut.carry}, 16'h1100);
    seq('{8'h23, 8'hff, 8'ha8, 8'h23, 8'h01, 8'h68, 8'h78});
    chk({accumOut, 6'h00, statusWordOut.carry, statusWordOut.auxCarry}, 16'h0003);
  endtask
  // table loads from current page and page three
  task automatic t_table;
    seq('{8'h23, 8'h37, 8'ha3});
    chk(accumOut, 8'h77);
    seq('{8'h23, 8'h37, 8'he3});
    chk(accumOut, 8'hf7);
  endtask
  // one acknowledged cycle; its strobe must clear the request
  task automatic dma_cycle(input logic wr);
    dmaWrite = wr;
    dmaGo = 1'b1;
    idle(7);
    chk(hostSel, 1'b1);
    idle(16);
    chk(p2Drive.level[6], 1'b0);
    dmaGo = 1'b0;
  endtask
  // handshake: plain select first, then acknowledge only
  task automatic t_dma;
    hostCs_n = 1'b0;
    idle(6);
    chk(hostSel, 1'b1);
    hostCs_n = 1'b1;
    seq('{8'he5, 8'h23, 8'h40, 8'h3a});
    chk({p2Drive.level[6], p2Drive.oeN[7:6]}, 3'h6);
    dma_cycle(1'b0);
    seq('{8'h3a});
    chk(p2Drive.level[6], 1'b1);
    seq('{8'he5});
    chk(p2Drive.level[6], 1'b0);
    seq('{8'h3a});
    dma_cycle(1'b1);
    hostCs_n = 1'b0;
    idle(8);
    chk(hostSel, 1'b0);
    hostCs_n = 1'b1;
  endtask
  // buffer flags on port-2 bits 4 and 5, read back through the pins
  task automatic t_flags;
    seq('{8'hf5, 8'h23, 8'h30, 8'h3a});
    chk({p2Drive.level[5:4], p2Drive.oeN[5:4]}, 4'hc);
    seq('{8'h23, 8'h10, 8'h3a});
    chk(p2Drive.level[5:4], 2'h1);
    ibfFlag = 1'b1;
    seq('{8'h23, 8'h30, 8'h3a});
    chk(p2Drive.level[5:4], 2'h1);
    seq('{8'h0a});
    chk(accumOut, 8'h10);
  endtask

  initial begin
    idle(20);
    rst_n = 1'b1;
    idle(1);
    chk(p2Drive, 16'hffff);
    t_moves;
    t_status;
    t_add;
    t_table;
    t_dma;
    t_flags;
    print_verdict;
  end
  // two thousand cycles leaves ample room over the scenario list
  initial begin
    #200000;
    fails++;
    print_verdict;
  end
endmodule

// >>> testbench/smcu_far_side.sv
// far-side model: program memory table and a dma controller
// assumes the core's table request and port-2 request pin, one 100 ns clock
`timescale 1ns/1ps
module smcu_far_side (
  input  wire logic                       clk_sys,
  input  wire smcu_pkg::smcu_tbl_req_type tblReq,
  input  wire logic                       reqPin,
  input  wire logic                       dmaGo,
  input  wire logic                       dmaWrite,
  output logic                            tblDataValid = 1'b0,
  output logic [7:0]                      tblData = 8'h00,
  output logic                            ackPin,
  output logic                            rdPin_n,
  output logic                            wrPin_n
);
  logic [2:0] waitCnt = 3'h0;
  logic [3:0] dmaCnt = 4'h0;
  // table answers late; data bus toggles outside the answer cycle
  always @(posedge clk_sys) begin
    tblDataValid <= tblReq.valid && waitCnt == 3'h2;
    waitCnt <= tblReq.valid && !tblDataValid ? waitCnt + 3'h1 : 3'h0;
    tblData <= tblReq.valid && waitCnt == 3'h2 ?
               tblReq.addr[7:0] ^ {tblReq.addr[9:8], 6'h00} : ~tblData;
  end
  // selects only through acknowledge, strobe held past the pin filter
  always @(posedge clk_sys) begin
    dmaCnt <= !dmaGo ? 4'h0 :
              (reqPin || dmaCnt != 4'h0) && dmaCnt != 4'hf ? dmaCnt + 4'h1 : dmaCnt;
  end
  assign ackPin  = dmaCnt != 4'h0;
  // one strobe per cycle, chosen by the transfer direction
  assign rdPin_n = dmaWrite || dmaCnt < 4'h8 || dmaCnt > 4'hd;
  assign wrPin_n = !dmaWrite || dmaCnt < 4'h8 || dmaCnt > 4'hd;
endmodule
